// [design/wwdt_map.svh]
`ifndef WWDT_MAP_SVH
`define WWDT_MAP_SVH

// register offsets on the plain register port
`define WWDT_ADDR_CTRL      4'h0
`define WWDT_ADDR_STATUS    4'h1
`define WWDT_ADDR_CCP       4'h4

// control register fields
`define WWDT_CTRL_PER_LSB   0
`define WWDT_CTRL_PER_MSB   3
`define WWDT_CTRL_WIN_LSB   4
`define WWDT_CTRL_WIN_MSB   7
`define WWDT_CTRL_RESET     8'h00

// status register fields
`define WWDT_STAT_LOCK_BIT  7
`define WWDT_STAT_SYNC_BIT  0

// change protection: arbitrary key, open for a few bus cycles
`define WWDT_CCP_KEY        8'ha5
`define WWDT_CCP_WINDOW     3'h4

// timing
`define WWDT_CLK_HZ         32'h017d7840
`define WWDT_TICK_HZ        32'h00000400
`define WWDT_SYNC_TICKS     2'h2
`define WWDT_TO_BASE_TICKS  14'h0008
`define WWDT_SEL_MAX        4'hb
`define WWDT_SEL_ONE        4'h1
`define WWDT_SEL_OFF        4'h0

`endif

// [design/wwdt_pkg.sv]
package wwdt_pkg;

    typedef logic [3:0] wwdt_sel_t;
    typedef logic [13:0] wwdt_cnt_t;

    typedef enum logic [2:0] {
        WWDT_ST_OFF    = 3'b001,
        WWDT_ST_CLOSED = 3'b010,
        WWDT_ST_OPEN   = 3'b100
    } wwdt_state_t;

endpackage

// [design/wwdt_core_if.sv]
`timescale 1ns/10ps
interface wwdt_core_if;
    import wwdt_pkg::*;

    logic      tick;
    logic      enable;
    logic      halt;
    logic      clear;
    wwdt_sel_t period;
    wwdt_sel_t window;
    logic      expire;
    logic      closed;

    modport core (
        input  tick,
        input  enable,
        input  halt,
        input  clear,
        input  period,
        input  window,
        output expire,
        output closed
    );

    modport ctrl (
        output tick,
        output enable,
        output halt,
        output clear,
        output period,
        output window,
        input  expire,
        input  closed
    );
endinterface

// [design/wwdt_core.sv]
`timescale 1ns/10ps
`include "wwdt_map.svh"
module wwdt_core (
    input  wire logic clk_i,
    input  wire logic rst_i,
    wwdt_core_if.core cif
);
    import wwdt_pkg::*;

    wwdt_state_t state_ff;
    wwdt_state_t nxt_state;
    wwdt_cnt_t   cnt_ff;
    wwdt_cnt_t   nxt_cnt;
    logic        expire_ff;
    logic        nxt_expire;
    wwdt_cnt_t   open_len;
    wwdt_cnt_t   closed_len;

    // reserved selections behave as the longest period
    function automatic wwdt_cnt_t sel_len(input wwdt_sel_t sel);
        wwdt_sel_t s;
        s = (sel > `WWDT_SEL_MAX) ? `WWDT_SEL_MAX : sel;
        sel_len = `WWDT_TO_BASE_TICKS << (s - `WWDT_SEL_ONE); // [R3]
    endfunction

    assign open_len   = sel_len(cif.period);
    assign closed_len = sel_len(cif.window);

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_expire = 1'b0;
        if (!cif.enable) begin
            nxt_state = WWDT_ST_OFF; // [R9]
            nxt_cnt   = '0;
        end else if (cif.halt) begin
            // halted cpu: counter reset, first closed window skipped afterwards
            nxt_state = WWDT_ST_OPEN;
            nxt_cnt   = '0;
        end else begin
            case (state_ff)
                WWDT_ST_OFF: begin
                    // window only arms after the first clear
                    nxt_state = WWDT_ST_OPEN;
                    nxt_cnt   = '0;
                end
                WWDT_ST_CLOSED: begin
                    if (cif.window == `WWDT_SEL_OFF) begin
                        nxt_state = WWDT_ST_OPEN; // [R6]
                        nxt_cnt   = '0;
                    end else if (cif.clear) begin
                        nxt_expire = 1'b1; // [R5]
                        nxt_state  = WWDT_ST_OPEN;
                        nxt_cnt    = '0;
                    end else if (cif.tick) begin
                        if (cnt_ff == closed_len - 14'h0001) begin
                            nxt_state = WWDT_ST_OPEN; // [R10]
                            nxt_cnt   = '0;
                        end else begin
                            nxt_cnt = cnt_ff + 14'h0001;
                        end
                    end
                end
                WWDT_ST_OPEN: begin
                    if (cif.clear) begin
                        nxt_cnt   = '0; // [R4]
                        nxt_state = (cif.window != `WWDT_SEL_OFF) ? WWDT_ST_CLOSED : WWDT_ST_OPEN; // [R10]
                    end else if (cif.tick) begin
                        if (cnt_ff == open_len - 14'h0001) begin
                            nxt_expire = 1'b1; // [R1] [R5]
                            nxt_cnt    = '0;
                        end else begin
                            nxt_cnt = cnt_ff + 14'h0001; // [R1]
                        end
                    end
                end
                default: begin
                    nxt_state = WWDT_ST_OFF;
                    nxt_cnt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= WWDT_ST_OFF;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expire_ff <= 1'b0;
        end else begin
            expire_ff <= nxt_expire;
        end
    end

    assign cif.expire = expire_ff;
    assign cif.closed = (state_ff == WWDT_ST_CLOSED);
endmodule

// [design/wwdt_top.sv]
// Notes on behaviour
// (R1) Enabled timer counts continuously; missing clear before time-out requests system reset. Code holds the count at zero while debug_halt_i is high.
// (R2) Timer advances on a 1.024 kHz tick independent of bus activity.
// (R3) Eleven time-out selections, 8 to 8192 ticks, roughly 8 ms to 8 s.
// (R4) Each clear instruction restarts the time-out count.
// (R5) Window mode: clear too early or too late requests system reset.
// (R6) Only normal mode and window mode exist, chosen by window field.
// (R7) Once enabled, timer keeps running in every power state.
// (R8) Settings guarded by protected-write unlock and by a lock bit.
// (R9) Non-zero period field enables the watchdog; zero period disables it.
// (R10) Non-zero window sets closed length; open period always follows closed.
// (R11) Lock makes control unchangeable; software sets lock, clears only in debug.
// (R12) Control writes synchronised to tick domain; pending flag shown, writes then refused.
// (R13) Reset request made in tick domain and held until system reset arrives.
`timescale 1ns/10ps
`include "wwdt_map.svh"
module wwdt_top #(
    parameter int unsigned TICK_DIV = `WWDT_CLK_HZ / `WWDT_TICK_HZ
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       watchdog_clear_instruction_i,
    input  wire logic       debug_i,
    input  wire logic       debug_halt_i,
    input  wire logic [7:0] fuse_ctrl_i,
    output logic            sys_rst_o,
    output logic            sync_pending_flag_o
);
    import wwdt_pkg::*;

    wwdt_core_if cif ();

    logic [14:0] div_cnt_ff;
    logic        tick_ff;
    logic        boot_ff;
    logic [7:0]  ctrl_ff;
    logic [7:0]  active_ff;
    logic        lock_ff;
    logic        sync_busy_ff;
    logic [1:0]  sync_cnt_ff;
    logic [2:0]  ccp_cnt_ff;
    logic        clr_pend_ff;
    logic [1:0]  clr_cnt_ff;
    logic        clr_go_ff;
    logic [7:0]  rdata_ff;
    logic        sys_rst_ff;
    logic        ccp_open;
    logic        ctrl_wr_ok;
    logic        lock_wr;

    assign ccp_open   = (ccp_cnt_ff != 3'h0);
    assign ctrl_wr_ok = wr_i && (addr_i == `WWDT_ADDR_CTRL) && ccp_open && !lock_ff && !sync_busy_ff; // [R8] [R11] [R12]
    assign lock_wr    = wr_i && (addr_i == `WWDT_ADDR_STATUS) && ccp_open; // [R8]

    // free-running tick divider; stands in for the low-power oscillator and has no gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else if (div_cnt_ff == 15'(TICK_DIV - 1)) begin
            div_cnt_ff <= '0;
            tick_ff    <= 1'b1; // [R2] [R7]
        end else begin
            div_cnt_ff <= div_cnt_ff + 15'h0001;
            tick_ff    <= 1'b0;
        end
    end

    // fuse straps sampled in the first cycle after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_ff <= 1'b1;
        end else begin
            boot_ff <= 1'b0;
        end
    end

    // key write opens a short window for protected writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ccp_cnt_ff <= 3'h0;
        end else if (wr_i && (addr_i == `WWDT_ADDR_CCP) && (wdata_i == `WWDT_CCP_KEY)) begin
            ccp_cnt_ff <= `WWDT_CCP_WINDOW; // [R8]
        end else if (ccp_open) begin
            ccp_cnt_ff <= ccp_cnt_ff - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_ff <= 1'b0;
        end else if (boot_ff) begin
            lock_ff <= (fuse_ctrl_i[`WWDT_CTRL_PER_MSB:`WWDT_CTRL_PER_LSB] != `WWDT_SEL_OFF);
        end else if (lock_wr) begin
            if (wdata_i[`WWDT_STAT_LOCK_BIT]) begin
                lock_ff <= 1'b1; // [R11]
            end else if (debug_i) begin
                lock_ff <= 1'b0; // [R11]
            end
        end
    end

    // shadow value is readable at once, the counter sees it after the sync
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `WWDT_CTRL_RESET;
        end else if (boot_ff) begin
            ctrl_ff <= fuse_ctrl_i;
        end else if (ctrl_wr_ok) begin
            ctrl_ff <= wdata_i; // [R9] [R10]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_ff    <= `WWDT_CTRL_RESET;
            sync_busy_ff <= 1'b0;
            sync_cnt_ff  <= 2'h0;
        end else if (boot_ff) begin
            active_ff    <= fuse_ctrl_i;
            sync_busy_ff <= 1'b0;
            sync_cnt_ff  <= 2'h0;
        end else if (ctrl_wr_ok) begin
            sync_busy_ff <= 1'b1; // [R12]
            sync_cnt_ff  <= 2'h0;
        end else if (sync_busy_ff && tick_ff) begin
            if (sync_cnt_ff == `WWDT_SYNC_TICKS - 2'h1) begin
                active_ff    <= ctrl_ff; // [R12]
                sync_busy_ff <= 1'b0;
                sync_cnt_ff  <= 2'h0;
            end else begin
                sync_cnt_ff <= sync_cnt_ff + 2'h1;
            end
        end
    end

    // clear instruction crosses in over tick edges; a new one wins over the retire
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clr_pend_ff <= 1'b0;
            clr_cnt_ff  <= 2'h0;
            clr_go_ff   <= 1'b0;
        end else if (clr_pend_ff && tick_ff && (clr_cnt_ff == `WWDT_SYNC_TICKS - 2'h1)) begin
            clr_pend_ff <= watchdog_clear_instruction_i;
            clr_cnt_ff  <= 2'h0;
            clr_go_ff   <= 1'b1; // [R4]
        end else begin
            clr_go_ff <= 1'b0;
            if (watchdog_clear_instruction_i) begin
                clr_pend_ff <= 1'b1;
            end
            if (clr_pend_ff && tick_ff) begin
                clr_cnt_ff <= clr_cnt_ff + 2'h1;
            end
        end
    end

    assign cif.tick   = tick_ff;
    assign cif.enable = (active_ff[`WWDT_CTRL_PER_MSB:`WWDT_CTRL_PER_LSB] != `WWDT_SEL_OFF); // [R9]
    assign cif.halt   = debug_halt_i;
    assign cif.clear  = clr_go_ff;
    assign cif.period = active_ff[`WWDT_CTRL_PER_MSB:`WWDT_CTRL_PER_LSB];
    assign cif.window = active_ff[`WWDT_CTRL_WIN_MSB:`WWDT_CTRL_WIN_LSB]; // [R6]

    wwdt_core u_core (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cif   (cif)
    );

    // sticky until the system reset comes back around
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_rst_ff <= 1'b0;
        end else if (cif.expire) begin
            sys_rst_ff <= 1'b1; // [R13] [R1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `WWDT_ADDR_CTRL: begin
                    rdata_ff <= ctrl_ff;
                end
                `WWDT_ADDR_STATUS: begin
                    rdata_ff <= 8'h00;
                    rdata_ff[`WWDT_STAT_LOCK_BIT] <= lock_ff;
                    rdata_ff[`WWDT_STAT_SYNC_BIT] <= sync_busy_ff; // [R12]
                end
                default: begin
                    rdata_ff <= 8'h00;
                end
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_o             = rdata_ff;
    assign sys_rst_o           = sys_rst_ff;
    assign sync_pending_flag_o = sync_busy_ff;
endmodule

// [verif/wwdt_top_asserts.sv]
`timescale 1ns/10ps
`include "wwdt_map.svh"
module wwdt_top_asserts #(
    parameter int unsigned TICK_DIV = 2
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] fuse_ctrl_i,
    input wire logic       sys_rst_o,
    input wire logic       sync_pending_flag_o
);
    logic [3:0]  key_age_ff;
    logic        rst_d_ff;
    logic        armed_ff;
    int unsigned sync_cnt_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            key_age_ff <= 4'hf;
        else if (wr_i && addr_i == `WWDT_ADDR_CCP && wdata_i == `WWDT_CCP_KEY)
            key_age_ff <= 4'h0;
        else if (key_age_ff != 4'hf)
            key_age_ff <= key_age_ff + 4'h1;
    end
    always_ff @(posedge clk_i) rst_d_ff <= rst_i;
    // conservative: any attempt that might have enabled counting
    always_ff @(posedge clk_i) begin
        if (rst_i)
            armed_ff <= 1'b0;
        else if ((rst_d_ff && fuse_ctrl_i[3:0] != 4'h0) ||
                 (wr_i && addr_i == `WWDT_ADDR_CTRL && key_age_ff <= 4'h3 && wdata_i[3:0] != 4'h0))
            armed_ff <= 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !sync_pending_flag_o)
            sync_cnt_ff <= 0;
        else
            sync_cnt_ff <= sync_cnt_ff + 1;
    end

    rst_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) sys_rst_o |=> sys_rst_o)
        else $error("reset request dropped");
    off_no_rst_a: assert property (@(posedge clk_i) disable iff (rst_i) !armed_ff |-> !sys_rst_o)
        else $error("reset request while never enabled");
    key_needed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sync_pending_flag_o) |-> key_age_ff <= 4'h7)
        else $error("control transfer without key");
    sync_bound_a: assert property (@(posedge clk_i) disable iff (rst_i) sync_cnt_ff <= 3 * TICK_DIV + 4)
        else $error("sync pending too long");
    sync_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sync_pending_flag_o) |=> sync_pending_flag_o)
        else $error("sync pending too short");
    read_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && !(addr_i inside {`WWDT_ADDR_CTRL, `WWDT_ADDR_STATUS, `WWDT_ADDR_CCP}) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    status_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == `WWDT_ADDR_STATUS |=> rdata_o[6:1] == 6'h00)
        else $error("status spare bits set");
endmodule

bind wwdt_top wwdt_top_asserts #(.TICK_DIV(TICK_DIV)) u_wwdt_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fuse_ctrl_i(fuse_ctrl_i), .sys_rst_o(sys_rst_o),
    .sync_pending_flag_o(sync_pending_flag_o));

// [verif/wwdt_cpu_model.sv]
`timescale 1ns/10ps
`include "wwdt_map.svh"
module wwdt_cpu_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       sync_pending_flag_i,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            clear_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        clear_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d; // released data must not look like the last write
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        // data stands only between the two rising edges after the strobe
        @(negedge clk_i);
        d = rdata_i;
    endtask
    task automatic wait_sync;
        // sampled off the edge, so a flag raised by this very edge is seen
        @(negedge clk_i);
        for (int i = 0; i < 64 && sync_pending_flag_i !== 1'b0; i++)
            @(negedge clk_i);
    endtask
    task automatic prot_wr(input logic [3:0] a, input logic [7:0] d);
        wait_sync();
        wr(`WWDT_ADDR_CCP, `WWDT_CCP_KEY);
        wr(a, d);
    endtask
    task automatic clr;
        @(posedge clk_i);
        clear_o <= 1'b1;
        @(posedge clk_i);
        clear_o <= 1'b0;
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
`include "wwdt_map.svh"
module testbench;
    localparam int unsigned TD = 2;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       debug_i = 1'b0;
    logic [7:0] fuse_ctrl_i = 8'h00;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] d;
    logic       wr;
    logic       rd;
    logic       clr;
    logic       sys_rst;
    logic       sync;
    int         failures = 0;
    int         n_tests = 0;
    int         n;

    always #20 clk_i = ~clk_i;

    wwdt_cpu_model u_cpu (.clk_i(clk_i), .rdata_i(rdata), .sync_pending_flag_i(sync), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .clear_o(clr));
    wwdt_top #(.TICK_DIV(TD)) u_wwdt_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .watchdog_clear_instruction_i(clr), .debug_i(debug_i),
        .debug_halt_i(1'b0), .fuse_ctrl_i(fuse_ctrl_i), .sys_rst_o(sys_rst), .sync_pending_flag_o(sync));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        u_cpu.rd(a, d);
        chk(d, exp);
    endtask
    task automatic do_reset(input logic [7:0] f);
        @(posedge clk_i);
        rst_i <= 1'b1;
        fuse_ctrl_i <= f;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic wait_rst(input int lim);
        n = 0;
        while (sys_rst !== 1'b1 && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        do_reset(8'h00);
        chk_rd(`WWDT_ADDR_CTRL, 8'h00);
        chk_rd(`WWDT_ADDR_STATUS, 8'h00);
        chk_rd(4'h2, 8'h00);
        u_cpu.wr(`WWDT_ADDR_CTRL, 8'h01);
        chk_rd(`WWDT_ADDR_CTRL, 8'h00);
        wait_rst(300);
        chk(sys_rst, 1'b0);
        $display("test disabled done");
        // time from write to reset request: sync, then 8<<(p-1) ticks, then two flops
        for (int p = 1; p <= 11; p++) begin
            do_reset(8'h00);
            u_cpu.prot_wr(`WWDT_ADDR_CTRL, 8'(p));
            chk_rd(`WWDT_ADDR_STATUS, 8'h01);
            chk(sync, 8'h01);
            chk_rd(`WWDT_ADDR_CTRL, 8'(p));
            chk(sync, 8'h00);
            wait_rst(20000);
            chk(8'(n >= (8 << (p - 1)) * TD - 4 && n <= (8 << (p - 1)) * TD + 6), 8'h01);
        end
        $display("test periods done");
        do_reset(8'h00);
        u_cpu.prot_wr(`WWDT_ADDR_CTRL, 8'h01);
        u_cpu.wait_sync();
        repeat (12) begin
            u_cpu.clr();
            repeat (6) @(posedge clk_i);
        end
        chk(sys_rst, 1'b0);
        wait_rst(60);
        chk(sys_rst, 1'b1);
        $display("test clear done");
        // closed 16 ticks, open 8: clears spaced 40 cycles land in the open slot
        do_reset(8'h00);
        u_cpu.prot_wr(`WWDT_ADDR_CTRL, 8'h21);
        u_cpu.wait_sync();
        repeat (4) begin
            u_cpu.clr();
            repeat (38) @(posedge clk_i);
        end
        chk(sys_rst, 1'b0);
        u_cpu.clr();
        repeat (10) @(posedge clk_i);
        chk(sys_rst, 1'b0);
        u_cpu.clr();
        wait_rst(30);
        chk(sys_rst, 1'b1);
        $display("test window done");
        do_reset(8'h00);
        u_cpu.prot_wr(`WWDT_ADDR_STATUS, 8'h80);
        chk_rd(`WWDT_ADDR_STATUS, 8'h80);
        u_cpu.prot_wr(`WWDT_ADDR_CTRL, 8'h03);
        chk_rd(`WWDT_ADDR_CTRL, 8'h00);
        u_cpu.prot_wr(`WWDT_ADDR_STATUS, 8'h00);
        chk_rd(`WWDT_ADDR_STATUS, 8'h80);
        @(posedge clk_i);
        debug_i <= 1'b1;
        u_cpu.prot_wr(`WWDT_ADDR_STATUS, 8'h00);
        chk_rd(`WWDT_ADDR_STATUS, 8'h00);
        @(posedge clk_i);
        debug_i <= 1'b0;
        u_cpu.wr(`WWDT_ADDR_CCP, `WWDT_CCP_KEY);
        repeat (4) @(posedge clk_i);
        u_cpu.wr(`WWDT_ADDR_CTRL, 8'h01);
        chk_rd(`WWDT_ADDR_CTRL, 8'h00);
        u_cpu.prot_wr(`WWDT_ADDR_CTRL, 8'h05);
        u_cpu.wr(`WWDT_ADDR_CTRL, 8'h07);
        chk_rd(`WWDT_ADDR_CTRL, 8'h05);
        $display("test lock done");
        do_reset(8'h01);
        chk_rd(`WWDT_ADDR_CTRL, 8'h01);
        u_cpu.rd(`WWDT_ADDR_STATUS, d);
        chk(d & 8'h80, 8'h80);
        wait_rst(60);
        chk(sys_rst, 1'b1);
        $display("test fuse done");
        final_report();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        $display("MISMATCH at %0t: run did not finish", $time);
        final_report();
    end
endmodule
